// *** fli_map.svh ***
// register map, field layout, reset values and vectors of the prioritizer
`ifndef FLI_MAP_SVH
`define FLI_MAP_SVH

// ==========================================================
// sizes
`define FLI_NSRC 13
`define FLI_NFLAG 16
`define FLI_NPIN 7

// ==========================================================
// register byte offsets
`define FLI_OFF_ENABLE 8'h00
`define FLI_OFF_EXT_ENABLE 8'h04
`define FLI_OFF_LOW_PRI 8'h08
`define FLI_OFF_HIGH_PRI 8'h0C
`define FLI_OFF_EXT_LOW_PRI 8'h10
`define FLI_OFF_EXT_HIGH_PRI 8'h14
`define FLI_OFF_FLAGS 8'h18
`define FLI_OFF_CTRL 8'h1C
`define FLI_OFF_STATUS 8'h20

// ==========================================================
// reset values
`define FLI_RST_ENABLE 8'h00
`define FLI_RST_EXT_ENABLE 5'h00
`define FLI_RST_PRI 7'h00
`define FLI_RST_EXT_PRI 5'h00
`define FLI_RST_CTRL 3'h0
`define FLI_RST_PINS 7'h7E

// ==========================================================
// field positions
`define FLI_EN_GLOBAL 7
`define FLI_CTRL_PF_EN 0
`define FLI_CTRL_EXT0_EDGE 1
`define FLI_CTRL_EXT1_EDGE 2
`define FLI_FLG_PF 0
`define FLI_FLG_EXT0 1
`define FLI_FLG_T0 2
`define FLI_FLG_EXT1 3
`define FLI_FLG_T1 4
`define FLI_FLG_S0RX 5
`define FLI_FLG_S0TX 6
`define FLI_FLG_T2OVF 7
`define FLI_FLG_T2EXT 8
`define FLI_FLG_S1RX 9
`define FLI_FLG_S1TX 10
`define FLI_FLG_EXT2 11
`define FLI_FLG_WD 15

// ==========================================================
// levels and vectors
`define FLI_LEVEL_PF 3'h4
`define FLI_VEC_PF 8'h33
`define FLI_VEC_EXT0 8'h03
`define FLI_VEC_T0 8'h0B
`define FLI_VEC_EXT1 8'h13
`define FLI_VEC_T1 8'h1B
`define FLI_VEC_S0 8'h23
`define FLI_VEC_T2 8'h2B
`define FLI_VEC_S1 8'h3B
`define FLI_VEC_EXT2 8'h43
`define FLI_VEC_EXT3 8'h4B
`define FLI_VEC_EXT4 8'h53
`define FLI_VEC_EXT5 8'h5B
`define FLI_VEC_WD 8'h63

`endif

// *** fli_pkg.sv ***
// types shared by the prioritizer modules
`default_nettype none
package fli_pkg;
	typedef enum logic [3:0] {
		FLI_SRC_PF = 4'h0,
		FLI_SRC_EXT0 = 4'h1,
		FLI_SRC_T0 = 4'h2,
		FLI_SRC_EXT1 = 4'h3,
		FLI_SRC_T1 = 4'h4,
		FLI_SRC_S0 = 4'h5,
		FLI_SRC_T2 = 4'h6,
		FLI_SRC_S1 = 4'h7,
		FLI_SRC_EXT2 = 4'h8,
		FLI_SRC_EXT3 = 4'h9,
		FLI_SRC_EXT4 = 4'hA,
		FLI_SRC_EXT5 = 4'hB,
		FLI_SRC_WD = 4'hC
	} fli_src_t;

	typedef logic [2:0] fli_level_t;

	typedef struct packed {
		logic flag;
	} fli_cell_t;

	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [6:0] sync3;
		logic [6:0] filt;
		logic [7:0] enable;
		logic [4:0] ext_enable;
		logic [6:0] low_pri;
		logic [6:0] high_pri;
		logic [4:0] ext_low_pri;
		logic [4:0] ext_high_pri;
		logic [2:0] ctrl;
		logic [4:0] svc;
		logic req;
		logic [7:0] vector;
		fli_level_t level;
		fli_src_t src;
		logic ack;
		logic [31:0] rdata;
	} fli_top_t;
endpackage
`default_nettype wire

// *** fli_arb_if.sv ***
// request and winner signals between the top and the arbiter
`timescale 1ns/10ps
`default_nettype none
`include "fli_map.svh"
interface fli_arb_if;
	logic [`FLI_NSRC-1:0] pending;
	logic [`FLI_NSRC-1:0][2:0] level;
	logic win_valid;
	logic [3:0] win_idx;
	logic [2:0] win_level;
	modport req (output pending, level, input win_valid, win_idx, win_level);
	modport arb (input pending, level, output win_valid, win_idx, win_level);
endinterface
`default_nettype wire

// *** fli_flag_cell.sv ***
// one request flag: set wins over clear, optional level tracking
`timescale 1ns/10ps
`default_nettype none
module fli_flag_cell (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic set_i,
	input wire logic clr_i,
	input wire logic track_i,
	input wire logic level_i,
	// flag
	output logic flag_o
);
	fli_pkg::fli_cell_t st;
	fli_pkg::fli_cell_t next_st;

	always_comb begin
		next_st = st;
		if (track_i) begin
			next_st.flag = level_i;
		end else begin
			next_st.flag = set_i | (st.flag & ~clr_i);
		end
		if (rst_i) begin
			next_st.flag = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign flag_o = st.flag;
endmodule // fli_flag_cell
`default_nettype wire

// *** fli_arbiter.sv ***
// level-then-natural-order winner selection
`timescale 1ns/10ps
`default_nettype none
`include "fli_map.svh"
module fli_arbiter (
	// clock and reset, used only for checking
	input wire logic clk_i,
	input wire logic rst_i,
	// requests and winner
	fli_arb_if.arb arb
);
	logic v;
	logic [3:0] idx;
	logic [2:0] lvl;
	logic better;

	// scanning in natural order with a strict compare keeps the earlier
	// source on a tie
	always_comb begin
		v = 1'b0;
		idx = 4'h0;
		lvl = 3'h0;
		for (int i = 0; i < `FLI_NSRC; i++) begin
			if (arb.pending[i] && (!v || arb.level[i] > lvl)) begin
				v = 1'b1;
				idx = 4'(i);
				lvl = arb.level[i];
			end
		end
		arb.win_valid = v;
		arb.win_idx = idx;
		arb.win_level = lvl;
	end

	// helper: a pending source earlier in order at same or higher level
	always_comb begin
		better = 1'b0;
		for (int i = 0; i < `FLI_NSRC; i++) begin
			if (arb.pending[i] && 4'(i) < idx && arb.level[i] >= lvl) begin
				better = 1'b1;
			end
		end
	end

	// ==========================================================
	// checks
	property p_pf_wins;
		@(posedge clk_i) disable iff (rst_i)
		arb.pending[0] |-> arb.win_valid && arb.win_idx == 4'h0;
	endproperty
	a_pf_wins: assert property (p_pf_wins)
		else $error("power-fail pending but not chosen");

	property p_tie_order;
		@(posedge clk_i) disable iff (rst_i)
		arb.win_valid |-> !better && arb.pending[arb.win_idx];
	endproperty
	a_tie_order: assert property (p_tie_order)
		else $error("winner breaks level or natural order");
endmodule // fli_arbiter
`default_nettype wire

// *** fli_top.sv ***
// five-level interrupt prioritizer with wishbone register slave
// What this block does
// - there are five levels 4 down to 0, level 4 being the power-fail only.
// - each other source picks level 3..0 from a low and a high priority bit.
// - an enabled pending power-fail beats every other source.
// - sources pending at one level are ranked by a fixed natural order.
// - the order is pf, ext0, t0, ext1, t1, ser0, t2, ser1, ext2..5, watchdog.
// - each source has its fixed vector address handed to the core.
// - timer 0 and 1 overflow flags clear when the core vectors to them.
// - ext0/ext1 flags clear on vectoring if edge mode, else follow the pin.
// - a flag sets on its condition whatever the enables say.
// - the global enable gates every source except power-fail.
// - power-fail is gated by its own enable only.
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "fli_map.svh"
module fli_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// asynchronous pins
	input wire logic vcc_low_i,
	input wire logic [5:0] ext_irq_n_i,
	// same-clock event pulses
	input wire logic timer0_ovf_i,
	input wire logic timer1_ovf_i,
	input wire logic timer2_ovf_i,
	input wire logic timer2_ext_i,
	input wire logic serial0_rx_i,
	input wire logic serial0_tx_i,
	input wire logic serial1_rx_i,
	input wire logic serial1_tx_i,
	input wire logic watchdog_evt_i,
	// processor core
	input wire logic irq_ack_i,
	input wire logic reti_i,
	output logic irq_req_o,
	output logic [7:0] irq_vector_o,
	output logic [2:0] irq_level_o
);
	fli_pkg::fli_top_t st;
	fli_pkg::fli_top_t next_st;
	fli_arb_if arb_if ();

	logic [`FLI_NFLAG-1:0] flags;
	logic [`FLI_NFLAG-1:0] fset;
	logic [`FLI_NFLAG-1:0] fclr;
	logic [`FLI_NFLAG-1:0] ftrack;
	logic [`FLI_NFLAG-1:0] flevel;
	logic [`FLI_NPIN-1:0] pin_agree;
	logic [`FLI_NPIN-1:0] next_filt;
	logic [`FLI_NPIN-1:0] pin_fall;
	logic pf_rise;
	logic wb_take;
	logic wb_wr;
	logic ack_take;
	logic [15:0] w1c;
	logic [12:0] raw;
	logic [12:0] en;
	logic [12:1] lo_bits;
	logic [12:1] hi_bits;
	logic cur_valid;
	logic [2:0] cur_lvl;
	logic take;
	logic [4:0] svc_pop;

	function automatic logic [7:0] vec_of(input fli_pkg::fli_src_t s);
		case (s)
			fli_pkg::FLI_SRC_PF: vec_of = `FLI_VEC_PF;
			fli_pkg::FLI_SRC_EXT0: vec_of = `FLI_VEC_EXT0;
			fli_pkg::FLI_SRC_T0: vec_of = `FLI_VEC_T0;
			fli_pkg::FLI_SRC_EXT1: vec_of = `FLI_VEC_EXT1;
			fli_pkg::FLI_SRC_T1: vec_of = `FLI_VEC_T1;
			fli_pkg::FLI_SRC_S0: vec_of = `FLI_VEC_S0;
			fli_pkg::FLI_SRC_T2: vec_of = `FLI_VEC_T2;
			fli_pkg::FLI_SRC_S1: vec_of = `FLI_VEC_S1;
			fli_pkg::FLI_SRC_EXT2: vec_of = `FLI_VEC_EXT2;
			fli_pkg::FLI_SRC_EXT3: vec_of = `FLI_VEC_EXT3;
			fli_pkg::FLI_SRC_EXT4: vec_of = `FLI_VEC_EXT4;
			fli_pkg::FLI_SRC_EXT5: vec_of = `FLI_VEC_EXT5;
			fli_pkg::FLI_SRC_WD: vec_of = `FLI_VEC_WD;
			default: vec_of = 8'h00;
		endcase
	endfunction

	// ==========================================================
	// pin filtering and flag events
	always_comb begin
		pin_agree = st.sync2 ~^ st.sync3;
		next_filt = (pin_agree & st.sync3) | (~pin_agree & st.filt);
		pin_fall = st.filt & ~next_filt;
		pf_rise = next_filt[0] & ~st.filt[0];
		wb_take = wb_cyc_i & wb_stb_i & ~st.ack;
		wb_wr = wb_take & wb_we_i &
			({2'b00, wb_adr_i[7:2]} == `FLI_OFF_FLAGS >> 2);
		// write-one-to-clear, per byte lane
		w1c = wb_wr ? (wb_dat_i[15:0] & {{8{wb_sel_i[1]}},
			{8{wb_sel_i[0]}}}) : 16'h0000;
		ack_take = irq_ack_i & st.req;
	end

	// hardware sets; a set in the clearing cycle still lands
	always_comb begin
		fset = {watchdog_evt_i, pin_fall[6:3], serial1_tx_i, serial1_rx_i,
			timer2_ext_i, timer2_ovf_i, serial0_tx_i, serial0_rx_i,
			timer1_ovf_i, pin_fall[2], timer0_ovf_i, pin_fall[1],
			pf_rise};
		fclr = w1c;
		fclr[`FLI_FLG_T0] = w1c[`FLI_FLG_T0] |
			(ack_take && st.src == fli_pkg::FLI_SRC_T0);
		fclr[`FLI_FLG_T1] = w1c[`FLI_FLG_T1] |
			(ack_take && st.src == fli_pkg::FLI_SRC_T1);
		fclr[`FLI_FLG_EXT0] = w1c[`FLI_FLG_EXT0] |
			(ack_take && st.src == fli_pkg::FLI_SRC_EXT0);
		fclr[`FLI_FLG_EXT1] = w1c[`FLI_FLG_EXT1] |
			(ack_take && st.src == fli_pkg::FLI_SRC_EXT1);
		ftrack = '0;
		ftrack[`FLI_FLG_EXT0] = ~st.ctrl[`FLI_CTRL_EXT0_EDGE];
		ftrack[`FLI_FLG_EXT1] = ~st.ctrl[`FLI_CTRL_EXT1_EDGE];
		flevel = '0;
		flevel[`FLI_FLG_EXT0] = ~next_filt[1];
		flevel[`FLI_FLG_EXT1] = ~next_filt[2];
	end

	for (genvar g = 0; g < `FLI_NFLAG; g++) begin : g_flag
		fli_flag_cell u_cell (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.set_i(fset[g]),
			.clr_i(fclr[g]),
			.track_i(ftrack[g]),
			.level_i(flevel[g]),
			.flag_o(flags[g])
		);
	end

	// ==========================================================
	// pending sources and levels
	always_comb begin
		raw = {flags[15:11], flags[10] | flags[9], flags[8] | flags[7],
			flags[6] | flags[5], flags[4:0]};
		en[0] = st.ctrl[`FLI_CTRL_PF_EN];
		en[12:1] = {st.ext_enable, st.enable[6:0]} &
			{12{st.enable[`FLI_EN_GLOBAL]}};
		lo_bits = {st.ext_low_pri, st.low_pri};
		hi_bits = {st.ext_high_pri, st.high_pri};
		arb_if.pending = raw & en;
		arb_if.level[0] = `FLI_LEVEL_PF;
		for (int i = 1; i < `FLI_NSRC; i++) begin
			arb_if.level[i] = {1'b0, hi_bits[i], lo_bits[i]};
		end
	end

	fli_arbiter u_arb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.arb(arb_if)
	);

	// ==========================================================
	// in-service levels and preemption
	always_comb begin
		cur_valid = |st.svc;
		cur_lvl = 3'h0;
		for (int i = 0; i < 5; i++) begin
			if (st.svc[i]) begin
				cur_lvl = 3'(i);
			end
		end
		svc_pop = st.svc;
		if (reti_i && cur_valid) begin
			svc_pop[cur_lvl] = 1'b0;
		end
		take = arb_if.win_valid &&
			(!cur_valid || arb_if.win_level > cur_lvl);
	end

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		next_st.sync1 = {ext_irq_n_i, vcc_low_i};
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		next_st.filt = next_filt;
		next_st.svc = svc_pop;
		if (ack_take) begin
			next_st.svc[st.level] = 1'b1;
		end
		// request drops in the ack cycle so a stale vector is never seen
		next_st.req = take & ~ack_take;
		next_st.src = fli_pkg::fli_src_t'(arb_if.win_idx);
		next_st.vector = vec_of(fli_pkg::fli_src_t'(arb_if.win_idx));
		next_st.level = arb_if.win_level;
		next_st.ack = wb_take;
		if (wb_take && wb_we_i && wb_sel_i[0]) begin
			case ({2'b00, wb_adr_i[7:2]})
				`FLI_OFF_ENABLE >> 2: next_st.enable = wb_dat_i[7:0];
				`FLI_OFF_EXT_ENABLE >> 2: next_st.ext_enable = wb_dat_i[4:0];
				`FLI_OFF_LOW_PRI >> 2: next_st.low_pri = wb_dat_i[6:0];
				`FLI_OFF_HIGH_PRI >> 2: next_st.high_pri = wb_dat_i[6:0];
				`FLI_OFF_EXT_LOW_PRI >> 2: next_st.ext_low_pri = wb_dat_i[4:0];
				`FLI_OFF_EXT_HIGH_PRI >> 2: next_st.ext_high_pri = wb_dat_i[4:0];
				`FLI_OFF_CTRL >> 2: next_st.ctrl = wb_dat_i[2:0];
				default: next_st.ctrl = st.ctrl;
			endcase
		end
		case ({2'b00, wb_adr_i[7:2]})
			`FLI_OFF_ENABLE >> 2: next_st.rdata = {24'h0, st.enable};
			`FLI_OFF_EXT_ENABLE >> 2: next_st.rdata = {27'h0, st.ext_enable};
			`FLI_OFF_LOW_PRI >> 2: next_st.rdata = {25'h0, st.low_pri};
			`FLI_OFF_HIGH_PRI >> 2: next_st.rdata = {25'h0, st.high_pri};
			`FLI_OFF_EXT_LOW_PRI >> 2: next_st.rdata = {27'h0, st.ext_low_pri};
			`FLI_OFF_EXT_HIGH_PRI >> 2:
				next_st.rdata = {27'h0, st.ext_high_pri};
			`FLI_OFF_FLAGS >> 2: next_st.rdata = {16'h0, flags};
			`FLI_OFF_CTRL >> 2: next_st.rdata = {29'h0, st.ctrl};
			`FLI_OFF_STATUS >> 2: next_st.rdata = {8'h0, st.vector, 3'h0,
				st.req, 1'b0, st.level, 3'h0, st.svc};
			default: next_st.rdata = 32'h0000_0000;
		endcase
		if (rst_i) begin
			next_st = '0;
			next_st.sync1 = `FLI_RST_PINS;
			next_st.sync2 = `FLI_RST_PINS;
			next_st.sync3 = `FLI_RST_PINS;
			next_st.filt = `FLI_RST_PINS;
			next_st.enable = `FLI_RST_ENABLE;
			next_st.ext_enable = `FLI_RST_EXT_ENABLE;
			next_st.low_pri = `FLI_RST_PRI;
			next_st.high_pri = `FLI_RST_PRI;
			next_st.ext_low_pri = `FLI_RST_EXT_PRI;
			next_st.ext_high_pri = `FLI_RST_EXT_PRI;
			next_st.ctrl = `FLI_RST_CTRL;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign wb_dat_o = st.rdata;
	assign wb_ack_o = st.ack;
	assign irq_req_o = st.req;
	assign irq_vector_o = st.vector;
	assign irq_level_o = st.level;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_enter;
		irq_req_o && irq_ack_i;
	endsequence

	sequence s_return;
		reti_i && !(irq_req_o && irq_ack_i) && (|st.svc);
	endsequence

	property p_pf_vector;
		irq_req_o && irq_level_o == `FLI_LEVEL_PF |->
			irq_vector_o == `FLI_VEC_PF;
	endproperty
	a_pf_vector: assert property (p_pf_vector)
		else $error("level 4 request without power-fail vector");

	property p_wd_vector;
		irq_req_o && st.src == fli_pkg::FLI_SRC_WD |->
			irq_vector_o == `FLI_VEC_WD && irq_level_o < `FLI_LEVEL_PF;
	endproperty
	a_wd_vector: assert property (p_wd_vector)
		else $error("watchdog request with wrong vector or level");

	property p_t0_clear;
		s_enter ##0 (st.src == fli_pkg::FLI_SRC_T0 && !timer0_ovf_i) |=>
			!flags[`FLI_FLG_T0];
	endproperty
	a_t0_clear: assert property (p_t0_clear)
		else $error("timer 0 flag not cleared on vectoring");

	property p_ext0_track;
		!st.ctrl[`FLI_CTRL_EXT0_EDGE] |=> flags[`FLI_FLG_EXT0] == !st.filt[1];
	endproperty
	a_ext0_track: assert property (p_ext0_track)
		else $error("level mode ext0 flag does not follow pin");

	property p_set_wins;
		timer1_ovf_i |=> flags[`FLI_FLG_T1];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("timer 1 event lost");

	property p_global_gate;
		!st.enable[`FLI_EN_GLOBAL] |->
			!arb_if.win_valid || arb_if.win_idx == 4'h0;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("source taken with global enable off");

	property p_pf_alone;
		flags[`FLI_FLG_PF] && st.ctrl[`FLI_CTRL_PF_EN] && !(|st.svc) &&
			!irq_ack_i && !reti_i |=>
			irq_req_o && irq_vector_o == `FLI_VEC_PF;
	endproperty
	a_pf_alone: assert property (p_pf_alone)
		else $error("enabled power-fail not requested");

	property p_preempt;
		irq_req_o |-> !cur_valid || irq_level_o > cur_lvl;
	endproperty
	a_preempt: assert property (p_preempt)
		else $error("request not above running level");

	property p_svc_push;
		s_enter |=> st.svc[$past(st.level)] && !irq_req_o;
	endproperty
	a_svc_push: assert property (p_svc_push)
		else $error("entered level not recorded");

	property p_svc_pop;
		s_return |=> $countones(st.svc) == $countones($past(st.svc)) - 1;
	endproperty
	a_svc_pop: assert property (p_svc_pop)
		else $error("return did not restore previous level");
endmodule // fli_top
`default_nettype wire

// *** fli_core_model.sv ***
// processor core stand-in: takes vectors and returns from service
`timescale 1ns/10ps
`default_nettype none
module fli_core_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic take_en_i,
	input wire logic [3:0] take_dly_i,
	input wire logic ret_cmd_i,
	// prioritizer side
	input wire logic irq_req_i,
	input wire logic [7:0] irq_vector_i,
	output logic irq_ack_o,
	output logic reti_o,
	// what was taken
	output logic [7:0] got_vector_o,
	output logic [7:0] takes_o
);
	logic [3:0] wait_cnt;

	// ==========================================================
	// vector fetch
	// the vector is captured at the edge that samples the ack, since the
	// prioritizer may swap in a newer winner while the core is slow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ack_o <= 1'b0;
			reti_o <= 1'b0;
			wait_cnt <= 4'h0;
			got_vector_o <= 8'h00;
			takes_o <= 8'h00;
		end else begin
			reti_o <= ret_cmd_i;
			irq_ack_o <= 1'b0;
			wait_cnt <= 4'h0;
			if (irq_ack_o && irq_req_i) begin
				got_vector_o <= irq_vector_i;
				takes_o <= takes_o + 8'h01;
			end else if (irq_req_i && take_en_i) begin
				if (wait_cnt >= take_dly_i) begin
					irq_ack_o <= 1'b1;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule // fli_core_model
`default_nettype wire

// *** fli_top_tb_top.sv ***
// self-checking bench for the five-level interrupt prioritizer
`timescale 1ns/10ps
`default_nettype none
module fli_top_tb_top;
	logic clk_i;
	logic rst_i;
	logic cyc, stb, we, ack, vcc_low, irq_ack, reti, irq_req;
	logic take_en, ret_cmd;
	logic [3:0] take_dly;
	logic [7:0] adr, irq_vec, got_vec, takes;
	logic [31:0] wdat, rdat, dat_o;
	logic [5:0] ext_n;
	logic [8:0] evt;
	logic [2:0] irq_lvl;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] vecs [12] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B,
		8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
	int fbit [12] = '{1, 2, 3, 4, 5, 7, 9, 11, 12, 13, 14, 15};

	fli_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.vcc_low_i(vcc_low), .ext_irq_n_i(ext_n), .timer0_ovf_i(evt[0]),
		.timer1_ovf_i(evt[1]), .timer2_ovf_i(evt[2]), .timer2_ext_i(evt[3]),
		.serial0_rx_i(evt[4]), .serial0_tx_i(evt[5]), .serial1_rx_i(evt[6]),
		.serial1_tx_i(evt[7]), .watchdog_evt_i(evt[8]),
		.irq_ack_i(irq_ack), .reti_i(reti), .irq_req_o(irq_req),
		.irq_vector_o(irq_vec), .irq_level_o(irq_lvl));

	fli_core_model i_core (.clk_i(clk_i), .rst_i(rst_i),
		.take_en_i(take_en), .take_dly_i(take_dly), .ret_cmd_i(ret_cmd),
		.irq_req_i(irq_req), .irq_vector_i(irq_vec), .irq_ack_o(irq_ack),
		.reti_o(reti), .got_vector_o(got_vec), .takes_o(takes));

	// ==========================================================
	// clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end

	// ==========================================================
	// tasks
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check_val(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 32'h0);
		check_val("register", exp, rdat);
	endtask

	// waits for a request at the given level, then checks the whole answer
	task automatic check_irq(input logic [7:0] v, input logic [2:0] l);
		int n;
		n = 0;
		while (!(irq_req === 1'b1 && irq_lvl === l) && n < 30) begin
			@(posedge clk_i);
			n++;
		end
		check_val("request", {20'h0, 1'b1, l, v},
			{20'h0, irq_req, irq_lvl, irq_vec});
	endtask

	task automatic check_idle();
		logic seen;
		seen = 1'b0;
		repeat (12) begin
			@(posedge clk_i);
			seen = seen | irq_req;
		end
		check_val("idle request", 32'h0, {31'h0, seen});
	endtask

	task automatic take(input logic [7:0] v);
		logic [7:0] t0;
		int n;
		t0 = takes;
		n = 0;
		take_en <= 1'b1;
		while (takes === t0 && n < 30) begin
			@(posedge clk_i);
			n++;
		end
		take_en <= 1'b0;
		check_val("take count", {24'h0, t0 + 8'h01}, {24'h0, takes});
		check_val("taken vector", {24'h0, v}, {24'h0, got_vec});
	endtask

	task automatic ret();
		@(posedge clk_i);
		ret_cmd <= 1'b1;
		@(posedge clk_i);
		ret_cmd <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic pulse(input logic [8:0] m);
		@(posedge clk_i);
		evt <= m;
		@(posedge clk_i);
		evt <= 9'h000;
	endtask

	task automatic pins(input logic [5:0] p);
		@(posedge clk_i);
		ext_n <= p;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, vcc_low, take_en, ret_cmd} = 6'h00;
		adr = 8'h00;
		wdat = 32'h0;
		ext_n = 6'h3F;
		evt = 9'h000;
		take_dly = 4'h0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a <= 36; a += 4) begin
			// idle status still shows the power-fail vector
			rd_check(8'(a), (a == 32) ? 32'h0033_0000 : 32'h0);
		end
		wb(8'h24, 1'b1, 32'hFFFFFFFF);
		rd_check(8'h24, 32'h0);
		// source enables on with global off, then global on
		wb(8'h1C, 1'b1, 32'h6);
		wb(8'h00, 1'b1, 32'h7F);
		pulse(9'h001);
		check_idle();
		rd_check(8'h18, 32'h4);
		wb(8'h00, 1'b1, 32'hFF);
		check_irq(8'h0B, 3'h0);
		take(8'h0B);
		rd_check(8'h18, 32'h4 & 32'h0);
		ret();
		// everything at level 0, served in natural order
		take_dly <= 4'h3;
		wb(8'h04, 1'b1, 32'h1F);
		pins(6'h00);
		pulse(9'h157);
		repeat (6) @(posedge clk_i);
		for (int i = 0; i < 12; i++) begin
			check_irq(vecs[i], 3'h0);
			take(vecs[i]);
			wb(8'h18, 1'b1, 32'h1 << fbit[i]);
			ret();
		end
		rd_check(8'h18, 32'h0);
		pins(6'h3F);
		// levels from the two priority bits, nesting
		wb(8'h0C, 1'b1, 32'h08);
		wb(8'h08, 1'b1, 32'h10);
		wb(8'h10, 1'b1, 32'h01);
		wb(8'h14, 1'b1, 32'h01);
		pulse(9'h012);
		check_irq(8'h1B, 3'h2);
		pins(6'h3B);
		check_irq(8'h43, 3'h3);
		take(8'h43);
		pins(6'h3F);
		wb(8'h18, 1'b1, 32'h800);
		check_idle();
		ret();
		check_irq(8'h1B, 3'h2);
		take(8'h1B);
		pins(6'h3B);
		check_irq(8'h43, 3'h3);
		take(8'h43);
		wb(8'h18, 1'b1, 32'h800);
		ret();
		ret();
		check_irq(8'h23, 3'h1);
		take(8'h23);
		wb(8'h18, 1'b1, 32'h20);
		ret();
		pins(6'h3F);
		// power-fail above all, and past the global enable
		take_dly <= 4'h0;
		wb(8'h1C, 1'b1, 32'h7);
		wb(8'h08, 1'b1, 32'h18);
		pulse(9'h002);
		check_irq(8'h1B, 3'h3);
		@(posedge clk_i);
		vcc_low <= 1'b1;
		check_irq(8'h33, 3'h4);
		take(8'h33);
		wb(8'h18, 1'b1, 32'h1);
		check_idle();
		ret();
		check_irq(8'h1B, 3'h3);
		wb(8'h00, 1'b1, 32'h7F);
		check_idle();
		@(posedge clk_i);
		vcc_low <= 1'b0;
		repeat (6) @(posedge clk_i);
		vcc_low <= 1'b1;
		check_irq(8'h33, 3'h4);
		take(8'h33);
		wb(8'h18, 1'b1, 32'h11);
		ret();
		// level-triggered ext0 and ext1 follow their pins
		wb(8'h1C, 1'b1, 32'h1);
		pins(6'h3C);
		repeat (6) @(posedge clk_i);
		rd_check(8'h18, 32'hA);
		wb(8'h18, 1'b1, 32'hA);
		rd_check(8'h18, 32'hA);
		pins(6'h3F);
		repeat (6) @(posedge clk_i);
		rd_check(8'h18, 32'h0);
		give_verdict();
	end
endmodule // fli_top_tb_top
`default_nettype wire
